/* File: common/psw_pkg.sv */
// ****************************************
// sleep and wake control constants
// ****************************************
package psw_pkg;

    localparam int unsigned CLK_HZ       = 125_000_000;
    localparam int unsigned TICK_MS      = 10;
    localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;

    // times in 10 ms units
    localparam logic [15:0] QUAL_TIME_MAX = 16'hfde8;
    localparam logic [15:0] QUAL_TIME_RST = 16'h01f4;
    localparam logic [15:0] SLEEP_DLY_RST = 16'h01f4;
    // output threshold in 0.1 % units
    localparam logic [15:0] THR_MAX       = 16'h03e8;
    localparam logic [15:0] THR_RST       = 16'h0032;

    // register byte offsets
    localparam logic [4:0] REG_CFG    = 5'h00;
    localparam logic [4:0] REG_THR    = 5'h04;
    localparam logic [4:0] REG_SDLY   = 5'h08;
    localparam logic [4:0] REG_QUAL   = 5'h0c;
    localparam logic [4:0] REG_LEVEL  = 5'h10;
    localparam logic [4:0] REG_WDEV   = 5'h14;
    localparam logic [4:0] REG_STAT   = 5'h18;
    localparam logic [4:0] REG_MASK   = 5'h1c;

    // cfg register fields
    localparam int unsigned CFG_MODE_LSB = 0;
    localparam int unsigned CFG_REV_BIT  = 2;

    // status fields
    localparam int unsigned ST_SLEEP  = 0;
    localparam int unsigned ST_WAKE   = 1;
    localparam int unsigned ST_ACTIVE = 2;
    localparam int unsigned EVT_W     = 2;

    typedef enum logic [1:0] {
        PSW_CFG_OFF   = 2'h0,
        PSW_CFG_LEVEL = 2'h1,
        PSW_CFG_WAKE  = 2'h2
    } psw_cfg_e;

    typedef enum logic [1:0] {
        PSW_RUN   = 2'b00,
        PSW_SLEEP = 2'b01,
        PSW_RAMP  = 2'b11
    } psw_state_e;

    typedef struct packed {
        logic [1:0]         mode;
        logic               reverse;
        logic        [15:0] thr;
        logic        [15:0] sleep_dly;
        logic        [15:0] qual;
        logic signed [15:0] level;
        logic signed [15:0] wdev;
    } psw_cfg_s;

    typedef struct packed {
        logic        pid_enable;
        logic        pid_auto;
        logic [15:0] pid_out;
        logic signed [15:0] process_variable_value;
        logic signed [15:0] present_setpoint;
        logic        at_minimum_motor_speed;
    } psw_proc_s;

endpackage

/* File: design/psw_tick.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// 10 ms tick divider
// ****************************************
module psw_tick
    import psw_pkg::*;
#(
    parameter int unsigned DIV = TICK_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic nrst,
    output logic      tick
);
    logic [31:0] cnt_q;
    wire         wrap = (cnt_q == DIV - 1);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 32'h0;
            tick  <= 1'b0;
        end else begin
            cnt_q <= wrap ? 32'h0 : cnt_q + 32'h1;
            tick  <= wrap;
        end
    end
endmodule
`default_nettype wire

/* File: design/psw_qual_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// qualification timer
// ****************************************
// counts ticks while cond holds; clears the moment cond drops
module psw_qual_timer (
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        tick,
    input  wire logic        cond,
    input  wire logic [15:0] limit,
    output logic             done
);
    logic [15:0] cnt_q;
    wire         reached = (cnt_q >= limit);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 16'h0;
        end else if (!cond) begin
            cnt_q <= 16'h0;
        end else if (tick && !reached) begin
            cnt_q <= cnt_q + 16'h1;
        end
    end

    // zero limit qualifies at once
    assign done = cond && reached;
endmodule
`default_nettype wire

/* File: design/psw_sleep_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - qualification time 0..650 s, default 5 s
// - level start: pv beyond level for time
// - wake: pv beyond setpoint deviation for time
// - sleep timer starts when output below threshold
// - delay elapsed: enter sleep, stop motor
// - asleep: motor stopped, pv still watched
// - level mode: count from level crossing
// - wake mode: count when deviation exceeded
// - qualified: run command, leave sleep
// - ramp to minimum speed, then closed loop
// - config 0 off, 1 level, 2 wake
// - sleep only with controller enabled, automatic
// - output threshold 0..100 %, default 5 %
// - sleep active alarm while asleep
module psw_sleep_ctrl
    import psw_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    input  wire logic               sys_clk,
    input  wire logic               nrst,
    // wishbone classic slave
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [4:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    // process controller side
    input  wire logic               pid_enable,
    input  wire logic               pid_auto,
    input  wire logic [15:0]        pid_out,
    input  wire logic signed [15:0] process_variable_value,
    input  wire logic signed [15:0] present_setpoint,
    input  wire logic               at_minimum_motor_speed,
    // motor side
    output logic                    motor_run_q,
    output logic                    ramp_to_min_q,
    output logic                    pid_in_control_q,
    output logic                    sleep_active_alarm,
    output logic                    irq
);

    // ****************************************
    // registers
    // ****************************************
    psw_cfg_s           cfg_q;
    psw_proc_s          proc_q;
    psw_state_e         state_q;
    psw_state_e         state_d;
    logic [EVT_W-1:0]   stat_q;
    logic [EVT_W-1:0]   mask_q;
    logic               tick;
    logic               sleep_done;
    logic               wake_done;

    // ****************************************
    // bus decode
    // ****************************************
    wire        bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        bus_wr   = bus_req && wb_we_i;
    wire        bus_rd   = bus_req && !wb_we_i;
    wire        wr_lo    = wb_sel_i[0];
    wire        wr_hi    = wb_sel_i[1];
    wire [15:0] wdat     = wb_dat_i[15:0];

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                            input logic lo, input logic hi);
        merge16 = {hi ? nw[15:8] : old[15:8], lo ? nw[7:0] : old[7:0]};
    endfunction

    function automatic logic [15:0] clip(input logic [15:0] v, input logic [15:0] mx);
        clip = (v > mx) ? mx : v;
    endfunction

    wire [15:0] thr_new  = clip(merge16(cfg_q.thr, wdat, wr_lo, wr_hi), THR_MAX);
    wire [15:0] sdly_new = clip(merge16(cfg_q.sleep_dly, wdat, wr_lo, wr_hi), QUAL_TIME_MAX);
    wire [15:0] qual_new = clip(merge16(cfg_q.qual, wdat, wr_lo, wr_hi), QUAL_TIME_MAX);

    // illegal config code 3 is kept out so sleep cannot half-enable
    wire [1:0]  mode_new = (wb_dat_i[1:0] == 2'h3) ? cfg_q.mode : wb_dat_i[1:0];

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0;
        unique case (wb_adr_i)
            REG_CFG:   rd_mux = {29'h0, cfg_q.reverse, cfg_q.mode};
            REG_THR:   rd_mux = {16'h0, cfg_q.thr};
            REG_SDLY:  rd_mux = {16'h0, cfg_q.sleep_dly};
            REG_QUAL:  rd_mux = {16'h0, cfg_q.qual};
            REG_LEVEL: rd_mux = {16'h0, cfg_q.level};
            REG_WDEV:  rd_mux = {16'h0, cfg_q.wdev};
            REG_STAT:  rd_mux = {29'h0, sleep_active_alarm, stat_q};
            REG_MASK:  rd_mux = {30'h0, mask_q};
            default:   rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_rd ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_q.mode      <= PSW_CFG_OFF;
            cfg_q.reverse   <= 1'b0;
            cfg_q.thr       <= THR_RST;
            cfg_q.sleep_dly <= SLEEP_DLY_RST;
            cfg_q.qual      <= QUAL_TIME_RST;
            cfg_q.level     <= 16'sh0;
            cfg_q.wdev      <= 16'sh0;
            mask_q          <= '0;
        end else if (bus_wr) begin
            unique case (wb_adr_i)
                REG_CFG: begin
                    if (wr_lo) begin
                        cfg_q.mode    <= mode_new;
                        cfg_q.reverse <= wb_dat_i[CFG_REV_BIT];
                    end
                end
                REG_THR:   cfg_q.thr       <= thr_new;
                REG_SDLY:  cfg_q.sleep_dly <= sdly_new;
                REG_QUAL:  cfg_q.qual      <= qual_new;
                REG_LEVEL: cfg_q.level     <= merge16(cfg_q.level, wdat, wr_lo, wr_hi);
                REG_WDEV:  cfg_q.wdev      <= merge16(cfg_q.wdev, wdat, wr_lo, wr_hi);
                REG_MASK:  if (wr_lo) mask_q <= wb_dat_i[EVT_W-1:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // process inputs, same clock domain
    // ****************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            proc_q <= '0;
        end else begin
            proc_q.pid_enable             <= pid_enable;
            proc_q.pid_auto               <= pid_auto;
            proc_q.pid_out                <= pid_out;
            proc_q.process_variable_value <= process_variable_value;
            proc_q.present_setpoint       <= present_setpoint;
            proc_q.at_minimum_motor_speed <= at_minimum_motor_speed;
        end
    end

    // ****************************************
    // conditions
    // ****************************************
    // pid output is in 0.1 % units, same scale as the threshold
    wire sleep_allowed = (cfg_q.mode != PSW_CFG_OFF)
                       && proc_q.pid_enable && proc_q.pid_auto;
    wire below_thr     = proc_q.pid_out < cfg_q.thr;
    wire sleep_cond    = (state_q == PSW_RUN) && sleep_allowed && below_thr;

    // 17-bit math so an extreme setpoint cannot wrap the limit
    wire signed [16:0] pv_ext  = {proc_q.process_variable_value[15],
                                  proc_q.process_variable_value};
    wire signed [16:0] sp_ext  = {proc_q.present_setpoint[15], proc_q.present_setpoint};
    wire signed [16:0] dev_ext = {cfg_q.wdev[15], cfg_q.wdev};
    wire signed [16:0] lvl_ext = {cfg_q.level[15], cfg_q.level};
    wire signed [16:0] pv_diff = pv_ext - sp_ext;

    wire level_ok = cfg_q.reverse ? (pv_ext > lvl_ext) : (pv_ext < lvl_ext);
    wire wake_ok  = cfg_q.reverse ? (pv_diff > dev_ext) : (pv_diff < -dev_ext);

    wire restart_ok = (cfg_q.mode == PSW_CFG_LEVEL) ? level_ok
                    : (cfg_q.mode == PSW_CFG_WAKE)  ? wake_ok : 1'b0;
    wire wake_cond  = (state_q == PSW_SLEEP) && restart_ok;

    // ****************************************
    // timers
    // ****************************************
    psw_tick #(
        .DIV (TICK_DIV)
    ) u_tick (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .tick    (tick)
    );

    psw_qual_timer u_sleep_tmr (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .tick    (tick),
        .cond    (sleep_cond),
        .limit   (cfg_q.sleep_dly),
        .done    (sleep_done)
    );

    psw_qual_timer u_wake_tmr (
        .sys_clk (sys_clk),
        .nrst    (nrst),
        .tick    (tick),
        .cond    (wake_cond),
        .limit   (cfg_q.qual),
        .done    (wake_done)
    );

    // ****************************************
    // state machine
    // ****************************************
    // disabling sleep while asleep restarts the motor rather than leaving it parked
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            PSW_RUN: begin
                if (sleep_done) state_d = PSW_SLEEP;
            end
            PSW_SLEEP: begin
                if (wake_done || cfg_q.mode == PSW_CFG_OFF) state_d = PSW_RAMP;
            end
            PSW_RAMP: begin
                if (proc_q.at_minimum_motor_speed) state_d = PSW_RUN;
            end
            default: state_d = PSW_RUN;
        endcase
    end

    wire ev_sleep = (state_q == PSW_RUN) && (state_d == PSW_SLEEP);
    wire ev_wake  = (state_q == PSW_SLEEP) && (state_d == PSW_RAMP);
    wire [EVT_W-1:0] ev_vec = {ev_wake, ev_sleep};
    wire stat_rd  = bus_rd && (wb_adr_i == REG_STAT);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= PSW_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            motor_run_q        <= 1'b1;
            ramp_to_min_q      <= 1'b0;
            pid_in_control_q   <= 1'b1;
            sleep_active_alarm <= 1'b0;
        end else begin
            motor_run_q        <= (state_d != PSW_SLEEP);
            ramp_to_min_q      <= (state_d == PSW_RAMP);
            pid_in_control_q   <= (state_d == PSW_RUN);
            sleep_active_alarm <= (state_d == PSW_SLEEP);
        end
    end

    // set wins over the clear by read
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            stat_q <= '0;
            irq    <= 1'b0;
        end else begin
            stat_q <= (stat_rd ? '0 : stat_q) | ev_vec;
            irq    <= |(((stat_rd ? '0 : stat_q) | ev_vec) & mask_q);
        end
    end

endmodule
`default_nettype wire

/* File: verif/psw_sleep_ctrl_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// sleep control checks
// ****
module psw_sleep_ctrl_sva (
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        pid_enable,
    input wire logic        pid_auto,
    input wire logic        at_minimum_motor_speed,
    input wire logic        motor_run_q,
    input wire logic        ramp_to_min_q,
    input wire logic        pid_in_control_q,
    input wire logic        sleep_active_alarm
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_stop;
        $fell(motor_run_q);
    endsequence
    sequence s_wake;
        $rose(motor_run_q);
    endsequence
    a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not idle");
    a_stop_alarm: assert property (s_stop |-> sleep_active_alarm)
        else $error("stop without alarm");
    a_alarm_stopped: assert property (sleep_active_alarm |-> !motor_run_q)
        else $error("motor runs asleep");
    // one input flop plus the output flop: the qualifying sample is two edges back
    a_sleep_auto: assert property (s_stop |-> $past(pid_enable && pid_auto, 2))
        else $error("sleep outside automatic");
    a_wake_ramp: assert property (s_wake |-> ramp_to_min_q && !pid_in_control_q)
        else $error("restart without ramp");
    a_ramp_excl: assert property (ramp_to_min_q |-> !pid_in_control_q)
        else $error("control during ramp");
    a_hand_back: assert property (ramp_to_min_q && at_minimum_motor_speed
        |-> ##[1:3] pid_in_control_q) else $error("no hand back");
endmodule
`default_nettype wire

/* File: verif/psw_motor_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// motor speed ramp model
// ****
module psw_motor_model #(
    parameter int MIN = 6
) (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       motor_run_q,
    input  wire logic [3:0] rate,
    output logic            at_min
);
    int speed;
    int div;
    // rate slows the ramp so both prompt and lazy drives are seen
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            speed <= MIN;
            div <= 0;
        end else if (div < rate) begin
            div <= div + 1;
        end else begin
            div <= 0;
            if (motor_run_q && speed < MIN) speed <= speed + 1;
            else if (!motor_run_q && speed > 0) speed <= speed - 1;
        end
    end
    assign at_min = speed >= MIN;
endmodule
`default_nettype wire

/* File: verif/psw_sleep_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// sleep control bench
// ****
module psw_sleep_ctrl_tb;
    import psw_pkg::*;
    logic              sys_clk = 1'b0, nrst = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic              wb_we_i = 1'b0, pid_enable = 1'b1, pid_auto = 1'b1;
    logic        [4:0] wb_adr_i = 5'h00;
    logic        [3:0] wb_sel_i = 4'h3, rate = 4'h0;
    logic       [31:0] wb_dat_i = 32'h0, wb_dat_o, expq[$];
    logic       [15:0] pid_out = 16'h0200;
    logic signed [15:0] process_variable_value = 16'sh0096, present_setpoint = 16'sh03e8;
    logic              at_minimum_motor_speed, wb_ack_o, motor_run_q, ramp_to_min_q;
    logic              pid_in_control_q, sleep_active_alarm, irq;
    logic        [2:0] cf[4] = '{3'h1, 3'h5, 3'h2, 3'h6};
    logic signed [15:0] good[4] = '{16'sh0032, 16'sh0096, 16'sh0352, 16'sh047e};
    logic signed [15:0] bad[4] = '{16'sh0096, 16'sh0032, 16'sh03b6, 16'sh041a};
    int                n_fail = 0, comparisons = 0, n;
    always #4 sys_clk = ~sys_clk;
    psw_sleep_ctrl #(.TICK_DIV(4)) dut (.sys_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pid_enable, .pid_auto,
        .pid_out, .process_variable_value, .present_setpoint, .at_minimum_motor_speed,
        .motor_run_q, .ramp_to_min_q, .pid_in_control_q, .sleep_active_alarm, .irq);
    psw_motor_model motor (.sys_clk, .nrst, .motor_run_q, .rate,
        .at_min(at_minimum_motor_speed));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        // a read that never came back is a mismatch too
        if (expq.size() != 0) n_fail++;
        $display("mismatches %0d, comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d,
                       input logic [31:0] e);
        int k;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        if (!w) expq.push_back(e);
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (k >= 20) begin
            n_fail++;
            end_sim();
        end
    endtask
    task automatic wait_run(input logic want, output int k);
        k = 0;
        while (motor_run_q !== want && k < 400) begin
            @(posedge sys_clk);
            k++;
        end
        if (k >= 400) begin
            n_fail++;
            end_sim();
        end
    endtask
    // read data is judged at the ack edge, while we is still held
    always @(posedge sys_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0) begin
            check(wb_dat_o, expq.pop_front());
        end
    end
    initial begin
        void'($urandom(28));
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        bus(REG_THR, 1'b0, 32'h0, {16'h0, THR_RST});
        bus(REG_QUAL, 1'b0, 32'h0, {16'h0, QUAL_TIME_RST});
        bus(5'h01, 1'b0, 32'h0, 32'h0);
        bus(REG_THR, 1'b1, 32'hffff, 32'h0);
        bus(REG_THR, 1'b0, 32'h0, {16'h0, THR_MAX});
        bus(REG_QUAL, 1'b1, 32'hffff, 32'h0);
        bus(REG_QUAL, 1'b0, 32'h0, {16'h0, QUAL_TIME_MAX});
        bus(REG_CFG, 1'b1, 32'h1, 32'h0);
        bus(REG_CFG, 1'b1, 32'h3, 32'h0);
        bus(REG_CFG, 1'b0, 32'h0, 32'h1);
        bus(REG_THR, 1'b1, 32'h32, 32'h0);
        bus(REG_SDLY, 1'b1, 32'h3, 32'h0);
        bus(REG_QUAL, 1'b1, 32'h3, 32'h0);
        bus(REG_LEVEL, 1'b1, 32'h64, 32'h0);
        bus(REG_WDEV, 1'b1, 32'h64, 32'h0);
        bus(REG_MASK, 1'b1, 32'h1, 32'h0);
        pid_auto <= 1'b0;
        pid_out <= 16'h0000;
        repeat (40) @(posedge sys_clk);
        check(motor_run_q, 1'b1);
        pid_auto <= 1'b1;
        pid_enable <= 1'b0;
        repeat (40) @(posedge sys_clk);
        check(motor_run_q, 1'b1);
        bus(REG_CFG, 1'b1, 32'h0, 32'h0);
        pid_enable <= 1'b1;
        repeat (40) @(posedge sys_clk);
        check(motor_run_q, 1'b1);
        for (int i = 0; i < 4; i++) begin
            bus(REG_CFG, 1'b1, {29'h0, cf[i]}, 32'h0);
            rate <= 4'($urandom % 4);
            process_variable_value <= bad[i];
            // short dips must not add up across gaps
            repeat (4) begin
                pid_out <= 16'($urandom % 50);
                repeat (6) @(posedge sys_clk);
                pid_out <= 16'h0200;
                repeat (3) @(posedge sys_clk);
            end
            check(motor_run_q, 1'b1);
            pid_out <= 16'($urandom % 50);
            wait_run(1'b0, n);
            check(n >= 8 && n <= 22, 1'b1);
            check(sleep_active_alarm, 1'b1);
            check(irq, 1'b1);
            bus(REG_STAT, 1'b0, 32'h0, i == 0 ? 32'h5 : 32'h7);
            repeat (2) @(posedge sys_clk);
            check(irq, 1'b0);
            repeat (4) begin
                process_variable_value <= good[i];
                repeat (6) @(posedge sys_clk);
                process_variable_value <= bad[i];
                repeat (3) @(posedge sys_clk);
            end
            check(motor_run_q, 1'b0);
            process_variable_value <= good[i];
            wait_run(1'b1, n);
            check(n >= 8 && n <= 22, 1'b1);
            check({ramp_to_min_q, pid_in_control_q, sleep_active_alarm}, 3'b100);
            pid_out <= 16'h0200;
            process_variable_value <= bad[i];
            n = 0;
            while (pid_in_control_q !== 1'b1 && n < 200) begin
                @(posedge sys_clk);
                n++;
            end
            if (n >= 200) begin
                n_fail++;
                end_sim();
            end
            check({ramp_to_min_q, pid_in_control_q}, 2'b01);
        end
        end_sim();
    end
endmodule
bind psw_sleep_ctrl psw_sleep_ctrl_sva chk (.sys_clk, .nrst, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .pid_enable, .pid_auto, .at_minimum_motor_speed, .motor_run_q,
    .ramp_to_min_q, .pid_in_control_q, .sleep_active_alarm);
`default_nettype wire
